/* File: rtl/homing_pkg.sv */
/*
  homing_pkg: constants, enums and carrier structs for the homing sequencer.
  assumes a 100 MHz mclk; long counts are overridable at the top module.
*/
package homing_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_FREQ_KHZ     = 100000;                         // mclk rate in kHz
  localparam int DOG_MIN_TIME_MS  = 10;                             // least dog on time, ms
  localparam int DOG_MIN_CYC_DEF  = DOG_MIN_TIME_MS * CLK_FREQ_KHZ; // least dog on time, cycles
  localparam int FILT_STEP_US     = 1000;                           // filter step, us
  localparam int FILT_STEP_CYC_DEF = FILT_STEP_US * CLK_FREQ_KHZ / 1000; // filter step, cycles

  // ****************************************
  // widths and field positions
  // ****************************************
  localparam int POS_W        = 32;  // position and distance width
  localparam int SPD_W        = 16;  // speed width
  localparam int ACC_W        = 16;  // time constant width
  localparam int FILT_W       = 24;  // filter counter width
  localparam int PTSEL_W      = 8;   // point-table selection inputs
  localparam int SPSEL_W      = 4;   // speed selection inputs
  localparam int DIGIT_LSB    = 0;   // lowest digit of the method code
  localparam int DIGIT_W      = 4;   // one digit

  // ****************************************
  // method codes (lowest digit)
  // ****************************************
  localparam logic [3:0] METHOD_DOG   = 4'h0;  // dog referenced
  localparam logic [3:0] METHOD_COUNT = 4'h1;  // count after dog front end
  localparam logic [3:0] METHOD_DATA  = 4'h2;  // current position as home

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,     // waiting for a start request
    ST_FAST,     // homing speed, dog not yet accepted
    ST_REAR,     // creep, waiting for dog rear end
    ST_TRAVEL,   // creep, post-dog travel
    ST_SEEK_Z,   // creep, waiting for z-phase
    ST_SHIFT,    // creep, shift distance
    ST_DONE      // one cycle, load home position
  } home_state_e;

  // configuration captured at start
  typedef struct packed {
    logic [15:0]      method;      // method parameter, digits
    logic             direction;   // search direction
    logic             dog_pol;     // 1: dog on means detected
    logic [SPD_W-1:0] home_speed;  // speed until dog
    logic [SPD_W-1:0] creep_speed; // speed after dog
    logic [POS_W-1:0] shift;       // home shift distance
    logic [POS_W-1:0] home_data;   // position loaded at completion
    logic [POS_W-1:0] post_dog;    // travel after dog front end
    logic [ACC_W-1:0] accel;       // point table 1 acceleration
    logic [ACC_W-1:0] decel;       // point table 1 deceleration
  } homing_cfg_s;

  // motion command to the drive
  typedef struct packed {
    logic             active;  // motion requested
    logic             dir;     // direction
    logic [SPD_W-1:0] speed;   // commanded speed
    logic [ACC_W-1:0] accel;   // acceleration constant
    logic [ACC_W-1:0] decel;   // deceleration constant
  } motion_cmd_s;

endpackage

/* File: rtl/input_filter.sv */
/*
  input_filter: per-bit delay filter for external inputs.
  assumes inputs synchronous to mclk; an output follows its input once the
  input has differed from it for limit+1 consecutive cycles.
*/
`timescale 1ns/10ps
module input_filter
  import homing_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic [W-1:0]      din,
  input  wire logic [FILT_W-1:0] limit,
  output logic      [W-1:0]      dout
);

  // ****************************************
  // per-bit filter
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      logic [FILT_W-1:0] cnt_reg;  // cycles spent differing
      logic              out_reg;  // filtered level of this bit

      // output changes only after the input has held its new level
      always_ff @(posedge mclk)
      begin
        if (!resetn)
        begin
          cnt_reg <= '0;
          out_reg <= 1'b0;
        end
        else if (din[gi] == out_reg)
          cnt_reg <= '0;
        else if (cnt_reg >= limit)
        begin
          cnt_reg <= '0;
          out_reg <= din[gi];  // R12
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end

      // one flip-flop per bit keeps the output word to a single driver per bit
      assign dout[gi] = out_reg;

      property p_filter_hold;
        @(posedge mclk) disable iff (!resetn)
        (din[gi] != dout[gi] && cnt_reg < limit) |=> (dout[gi] == $past(dout[gi]));
      endproperty
      a_filter_hold: assert property (p_filter_hold) else $error("filter passed a change early"); // R12
    end
  endgenerate

endmodule

/* File: rtl/servo_homing_sequencer.sv */
/*
  servo_homing_sequencer: home return sequencer, dog, count and data methods.
  assumes synchronous inputs; travel_pulse marks one unit of motion and
  z_phase one encoder index pulse, both single-cycle and unfiltered.
*/
// Notes on behaviour
// R1: manual mode: selector on, table inputs off
// R2: bcd use: speed selection inputs off
// R3: digit 1 count method, 2 data method
// R4: digit 0 runs dog method
// R5: dog method: z after rear end, shift
// R6: count: post-dog travel, then next z
// R7: count: dog accepted after 10 ms on
// R8: homing speed until dog, then creep
// R9: count: home is shift past z
// R10: point table 1 time constants always
// R11: completion loads home position data
// R12: inputs delayed by selected filter time
// R13: controller changes selection ahead of delays
// R14: data method: current position becomes home
// R15: dog detection follows polarity setting
// R16: search starts in configured direction
// R17: start ignored outside manual mode
`timescale 1ns/10ps
module servo_homing_sequencer
  import homing_pkg::*;
#(
  parameter int DOG_MIN_CYC   = DOG_MIN_CYC_DEF,  // least dog on time, cycles
  parameter int FILT_STEP_CYC = FILT_STEP_CYC_DEF // filter step, cycles
)(
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic               auto_manual_select,
  input  wire logic [PTSEL_W-1:0] point_table_select,
  input  wire logic [SPSEL_W-1:0] speed_select_inputs,
  input  wire logic               bcd_input_mode,
  input  wire logic               homing_start,
  input  wire logic               dog_in,
  input  wire logic               z_phase,
  input  wire logic               travel_pulse,
  input  wire logic [15:0]        homing_method_param,
  input  wire logic               homing_direction_param,
  input  wire logic [SPD_W-1:0]   homing_speed_param,
  input  wire logic [SPD_W-1:0]   creep_speed_param,
  input  wire logic [POS_W-1:0]   home_shift_distance_param,
  input  wire logic [POS_W-1:0]   home_position_data_param,
  input  wire logic [POS_W-1:0]   post_dog_travel_param,
  input  wire logic               dog_polarity_param,
  input  wire logic [1:0]         input_filter_time_param,
  input  wire logic [ACC_W-1:0]   pt1_accel_const,
  input  wire logic [ACC_W-1:0]   pt1_decel_const,
  output motion_cmd_s             motion_cmd_reg,
  output logic                    pos_load_reg,
  output logic      [POS_W-1:0]   pos_load_value_reg,
  output logic                    homing_busy_reg,
  output logic                    homing_done_reg
);

  // ****************************************
  // declarations
  // ****************************************
  localparam int NFILT = 3 + PTSEL_W + SPSEL_W;  // filtered input count

  logic [FILT_W-1:0] filt_limit_reg;  // filter length from setting
  logic [NFILT-1:0]  filt_out;        // filtered inputs
  logic              md_f;            // filtered mode selector
  logic              start_f;         // filtered start
  logic              dog_f;           // filtered dog
  logic [PTSEL_W-1:0] pt_f;           // filtered table selection
  logic [SPSEL_W-1:0] sp_f;           // filtered speed selection
  logic              start_prev_reg;  // start edge detection
  logic              start_req;       // start rising edge
  logic              manual_mode;     // manual home return selected
  logic              dog_act;         // dog detected per polarity
  homing_cfg_s       cfg_reg;         // configuration taken at start
  home_state_e       state_reg;       // sequencer state
  home_state_e       state_next;      // next state
  logic [31:0]       dog_cnt_reg;     // dog on time, cycles
  logic [POS_W-1:0]  dist_cnt_reg;    // distance moved in this phase
  logic [3:0]        method_digit;    // lowest method digit

  // ****************************************
  // input filtering
  // ****************************************

  // filter length follows the filter-setting input
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      filt_limit_reg <= '0;
    else
      filt_limit_reg <= FILT_W'(FILT_STEP_CYC * int'(input_filter_time_param)); // R12
  end

  input_filter #(
    .W      (NFILT)
  ) u_filter (
    .mclk   (mclk),
    .resetn (resetn),
    .din    ({auto_manual_select, homing_start, dog_in, point_table_select, speed_select_inputs}),
    .limit  (filt_limit_reg),
    .dout   (filt_out)
  );

  assign {md_f, start_f, dog_f, pt_f, sp_f} = filt_out;

  // start edge on the filtered input
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      start_prev_reg <= 1'b0;
    else
      start_prev_reg <= start_f;
  end

  assign start_req = start_f & ~start_prev_reg;

  // manual mode: selector on and the active selection group all off
  assign manual_mode = md_f && (bcd_input_mode ? (sp_f == '0) : (pt_f == '0)); // R1 R2 R17
  assign dog_act     = (dog_f == cfg_reg.dog_pol);  // R15
  assign method_digit = cfg_reg.method[DIGIT_LSB +: DIGIT_W];

  // ****************************************
  // configuration capture
  // ****************************************

  // parameters are frozen for the whole run
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      cfg_reg <= '0;
    else if (state_reg == ST_IDLE && start_req && manual_mode)
    begin
      cfg_reg.method      <= homing_method_param;
      cfg_reg.direction   <= homing_direction_param;
      cfg_reg.dog_pol     <= dog_polarity_param;
      cfg_reg.home_speed  <= homing_speed_param;
      cfg_reg.creep_speed <= creep_speed_param;
      cfg_reg.shift       <= home_shift_distance_param;
      cfg_reg.home_data   <= home_position_data_param;
      cfg_reg.post_dog    <= post_dog_travel_param;
      cfg_reg.accel       <= pt1_accel_const;
      cfg_reg.decel       <= pt1_decel_const;
    end
  end

  // ****************************************
  // state machine
  // ****************************************

  // next state from the current phase and its event
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (start_req && manual_mode)  // R17
        begin
          if (homing_method_param[DIGIT_LSB +: DIGIT_W] == METHOD_DATA)
            state_next = ST_DONE;  // R3 R14
          else if (homing_method_param[DIGIT_LSB +: DIGIT_W] == METHOD_COUNT ||
                   homing_method_param[DIGIT_LSB +: DIGIT_W] == METHOD_DOG)
            state_next = ST_FAST;  // R3 R4
        end
      end
      ST_FAST:
      begin
        if (method_digit == METHOD_COUNT)
        begin
          if (dog_act && dog_cnt_reg >= 32'(DOG_MIN_CYC - 1))
            state_next = ST_TRAVEL;  // R7
        end
        else if (dog_act)
          state_next = ST_REAR;  // R4 R15
      end
      ST_REAR:
      begin
        if (!dog_act)
          state_next = ST_SEEK_Z;  // R5
      end
      ST_TRAVEL:
      begin
        if (dist_cnt_reg >= cfg_reg.post_dog)
          state_next = ST_SEEK_Z;  // R6
      end
      ST_SEEK_Z:
      begin
        if (z_phase)
          state_next = ST_SHIFT;  // R5 R6
      end
      ST_SHIFT:
      begin
        if (dist_cnt_reg >= cfg_reg.shift)
          state_next = ST_DONE;  // R9
      end
      ST_DONE:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // dog on time, counted only while searching
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      dog_cnt_reg <= '0;
    else if (state_reg == ST_FAST && dog_act)
      dog_cnt_reg <= dog_cnt_reg + 1'b1;  // R7
    else
      dog_cnt_reg <= '0;
  end

  // distance counter, restarted at every phase change
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      dist_cnt_reg <= '0;
    else if (state_next != state_reg)
      dist_cnt_reg <= '0;
    else if (travel_pulse)
      dist_cnt_reg <= dist_cnt_reg + 1'b1;  // R6 R9
  end

  // ****************************************
  // outputs
  // ****************************************

  // motion command follows the next state
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      motion_cmd_reg <= '0;
    else
    begin
      motion_cmd_reg.active <= (state_next != ST_IDLE && state_next != ST_DONE);
      motion_cmd_reg.dir    <= (state_reg == ST_IDLE) ? homing_direction_param : cfg_reg.direction; // R16
      motion_cmd_reg.accel  <= (state_reg == ST_IDLE) ? pt1_accel_const : cfg_reg.accel; // R10
      motion_cmd_reg.decel  <= (state_reg == ST_IDLE) ? pt1_decel_const : cfg_reg.decel; // R10
      if (state_next == ST_FAST)
        motion_cmd_reg.speed <= (state_reg == ST_IDLE) ? homing_speed_param : cfg_reg.home_speed; // R8
      else if (state_next == ST_IDLE || state_next == ST_DONE)
        motion_cmd_reg.speed <= '0;
      else
        motion_cmd_reg.speed <= cfg_reg.creep_speed;  // R8
    end
  end

  // completion: one-cycle load of the home position value
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      pos_load_reg       <= 1'b0;
      pos_load_value_reg <= '0;
    end
    else
    begin
      pos_load_reg <= (state_next == ST_DONE);  // R11 R14
      if (state_next == ST_DONE)
        pos_load_value_reg <= (state_reg == ST_IDLE) ? home_position_data_param : cfg_reg.home_data; // R11
    end
  end

  // busy while running; done held until the next accepted dog or count start
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      homing_busy_reg <= 1'b0;
      homing_done_reg <= 1'b0;
    end
    else
    begin
      homing_busy_reg <= (state_next != ST_IDLE && state_next != ST_DONE);
      if (state_next == ST_DONE)
        homing_done_reg <= 1'b1;
      else if (state_reg == ST_IDLE && state_next != ST_IDLE)
        homing_done_reg <= 1'b0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_complete;
    pos_load_reg && !motion_cmd_reg.active ##1 !pos_load_reg;
  endsequence

  property p_ignore;
    @(posedge mclk) disable iff (!resetn)
    (state_reg == ST_IDLE && start_req && !manual_mode) |=> (state_reg == ST_IDLE && !homing_busy_reg);
  endproperty
  a_ignore: assert property (p_ignore) else $error("start accepted outside manual mode"); // R17

  property p_data_set;
    @(posedge mclk) disable iff (!resetn)
    (state_reg == ST_IDLE && start_req && manual_mode && homing_method_param[3:0] == METHOD_DATA)
      |=> (pos_load_value_reg == $past(home_position_data_param)) and s_complete;
  endproperty
  a_data_set: assert property (p_data_set) else $error("data method did not load home at once"); // R14

  property p_search_start;
    @(posedge mclk) disable iff (!resetn)
    (state_reg == ST_IDLE && start_req && manual_mode && homing_method_param[3:0] <= METHOD_COUNT)
      |=> motion_cmd_reg.active && motion_cmd_reg.speed == cfg_reg.home_speed
          && motion_cmd_reg.dir == cfg_reg.direction;
  endproperty
  a_search_start: assert property (p_search_start) else $error("search did not start correctly"); // R3

  property p_dog_front;
    @(posedge mclk) disable iff (!resetn)
    (state_reg == ST_FAST && method_digit == METHOD_DOG && (dog_f == cfg_reg.dog_pol))
      |=> state_reg == ST_REAR ##1 motion_cmd_reg.speed == cfg_reg.creep_speed || state_reg != ST_REAR;
  endproperty
  a_dog_front: assert property (p_dog_front) else $error("dog front end not followed by creep"); // R15

  property p_rear_then_z;
    @(posedge mclk) disable iff (!resetn)
    (state_reg == ST_REAR && !dog_act) |=> (state_reg == ST_SEEK_Z) ##0 (!z_phase)[*1] ##1 1'b1
      or (state_reg == ST_SEEK_Z && z_phase ##1 state_reg == ST_SHIFT);
  endproperty
  a_rear_then_z: assert property (p_rear_then_z) else $error("rear end did not lead to z search"); // R5

  property p_short_dog;
    @(posedge mclk) disable iff (!resetn)
    (state_reg == ST_FAST && method_digit == METHOD_COUNT && !dog_act) |=> state_reg == ST_FAST;
  endproperty
  a_short_dog: assert property (p_short_dog) else $error("dog accepted without on time"); // R7

  property p_travel_end;
    @(posedge mclk) disable iff (!resetn)
    (state_reg == ST_TRAVEL && dist_cnt_reg >= cfg_reg.post_dog) |=> state_reg == ST_SEEK_Z;
  endproperty
  a_travel_end: assert property (p_travel_end) else $error("post-dog travel not ended on distance"); // R6

  property p_shift_done;
    @(posedge mclk) disable iff (!resetn)
    (state_reg == ST_SHIFT && dist_cnt_reg >= cfg_reg.shift)
      |=> s_complete and (pos_load_value_reg == cfg_reg.home_data);
  endproperty
  a_shift_done: assert property (p_shift_done) else $error("shift end did not load home data"); // R9

  property p_creep;
    @(posedge mclk) disable iff (!resetn)
    (state_reg inside {ST_REAR, ST_TRAVEL, ST_SEEK_Z, ST_SHIFT} && $past(state_reg) != ST_IDLE)
      |-> motion_cmd_reg.speed == cfg_reg.creep_speed;
  endproperty
  a_creep: assert property (p_creep) else $error("creep speed not used after dog"); // R8

  property p_time_const;
    @(posedge mclk) disable iff (!resetn)
    (motion_cmd_reg.active && state_reg != ST_IDLE)
      |-> motion_cmd_reg.accel == cfg_reg.accel && motion_cmd_reg.decel == cfg_reg.decel;
  endproperty
  a_time_const: assert property (p_time_const) else $error("time constants not from table 1"); // R10

endmodule

/* File: dv/axis_model.sv */
/*
  axis_model: moving axis behind the sequencer; travel pulses, index
  pulses and a proximity dog switch placed along the travel.
  assumes motion_cmd_s from homing_pkg and a 100 MHz mclk.
*/
`timescale 1ns/10ps
module axis_model
  import homing_pkg::*;
#(
  parameter int Z_PER = 16  // travel units per index pulse
)(
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  motion_cmd_s           cmd,
  input  wire logic             clr,
  input  wire logic             dog_pol,
  input  wire logic [POS_W-1:0] dog_start,
  input  wire logic [POS_W-1:0] dog_len,
  output logic                  travel_pulse,
  output logic                  z_phase,
  output logic                  dog_in,
  output logic      [POS_W-1:0] pos
);
  logic [1:0] ph_reg;  // one travel unit every four cycles
  logic       on_dog;  // axis over the dog

  // ****************************************
  // motion, one unit per four cycles while commanded
  // ****************************************
  always_ff @(posedge mclk)
  begin
    travel_pulse <= 1'b0;
    z_phase      <= 1'b0;
    if (!resetn || clr)
    begin
      ph_reg <= 2'h0;
      pos    <= '0;
    end
    else if (cmd.active)
    begin
      ph_reg <= ph_reg + 2'h1;
      if (ph_reg == 2'h0)
      begin
        travel_pulse <= 1'b1;
        pos          <= pos + 1'b1;
      end
      // index pulse apart from travel pulses
      if (ph_reg == 2'h2 && pos % Z_PER == 0)
        z_phase <= 1'b1;
    end
  end

  // dog switch level follows the chosen polarity
  assign on_dog = pos >= dog_start && pos < dog_start + dog_len;
  assign dog_in = dog_pol ~^ on_dog;
endmodule

/* File: dv/tb_servo_homing_sequencer.sv */
/*
  tb_servo_homing_sequencer: random and corner runs of all methods.
  assumes short dog and filter counts and the axis model.
*/
`timescale 1ns/10ps
module tb_servo_homing_sequencer
  import homing_pkg::*;
;
  localparam int DMIN  = 20;
  localparam int FSTEP = 4;
  logic               mclk, resetn, auto_manual_select, bcd_input_mode, homing_start;
  logic               homing_direction_param, dog_polarity_param, clr, dog_in, z_phase;
  logic               travel_pulse, pos_load_reg, homing_busy_reg, homing_done_reg;
  logic [PTSEL_W-1:0] point_table_select;
  logic [SPSEL_W-1:0] speed_select_inputs;
  logic [15:0]        homing_method_param;
  logic [SPD_W-1:0]   homing_speed_param, creep_speed_param;
  logic [POS_W-1:0]   home_shift_distance_param, home_position_data_param, post_dog_travel_param;
  logic [POS_W-1:0]   dog_start, dog_len, pos, pc, pos_load_value_reg;
  logic [1:0]         input_filter_time_param;
  logic [ACC_W-1:0]   pt1_accel_const, pt1_decel_const;
  motion_cmd_s        motion_cmd_reg;
  int                 errors, checks_done, seed, loads;

  servo_homing_sequencer #(.DOG_MIN_CYC(DMIN), .FILT_STEP_CYC(FSTEP)) i_dut (
    .mclk, .resetn, .auto_manual_select, .point_table_select, .speed_select_inputs,
    .bcd_input_mode, .homing_start, .dog_in, .z_phase, .travel_pulse, .homing_method_param,
    .homing_direction_param, .homing_speed_param, .creep_speed_param,
    .home_shift_distance_param, .home_position_data_param, .post_dog_travel_param,
    .dog_polarity_param, .input_filter_time_param, .pt1_accel_const, .pt1_decel_const,
    .motion_cmd_reg, .pos_load_reg, .pos_load_value_reg, .homing_busy_reg, .homing_done_reg);

  axis_model i_axis (.mclk, .resetn, .cmd(motion_cmd_reg), .clr, .dog_pol(dog_polarity_param),
    .dog_start, .dog_len, .travel_pulse, .z_phase, .dog_in, .pos);

  // clock and completion counter
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (pos_load_reg === 1'b1)
      loads++;

  // ****************************************
  // helper tasks
  // ****************************************
  task automatic check(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic give_up;
    errors++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    test_done;
  endtask

  // selection changed well ahead of the start request
  task automatic mode(input logic a, input logic [7:0] p, input logic [3:0] s, input logic b);
    auto_manual_select  <= a;
    point_table_select  <= p;
    speed_select_inputs <= s;
    bcd_input_mode      <= b;
    tick(20);
  endtask

  // one homing request; ok says whether it must be taken
  task automatic run(input logic [3:0] m, input logic ok);
    int lat, l0, ds, dl, sh;
    logic [POS_W-1:0] z0;
    ds = 5 + {$random(seed)} % 16;
    dl = 20 + {$random(seed)} % 16;
    if (((ds + dl) & 15) == 0)
      dl++;
    @(posedge mclk);
    homing_method_param       <= {12'($random(seed)), m};
    home_position_data_param  <= $random(seed);
    home_shift_distance_param <= POS_W'({$random(seed)} % 4);
    post_dog_travel_param     <= POS_W'({$random(seed)} % 20);
    homing_speed_param        <= 16'h8000 | 16'($random(seed));
    creep_speed_param         <= 16'h7FFF & 16'($random(seed));
    pt1_accel_const           <= 16'($random(seed));
    pt1_decel_const           <= 16'($random(seed));
    dog_start                 <= POS_W'(ds);
    dog_len                   <= POS_W'(dl);
    clr                       <= 1'b1;
    @(posedge mclk);
    clr          <= 1'b0;
    homing_start <= 1'b1;
    #1;
    l0  = loads;
    pc  = '1;
    lat = 0;
    // with no shift the stop leaves on the edge that still moves the axis one unit
    sh  = home_shift_distance_param + (home_shift_distance_param == 0);
    if (!ok)
    begin
      tick(40);
      check(loads - l0, 0);
      check(homing_busy_reg, 0);
    end
    else if (m == METHOD_DATA)
    begin
      while (pos_load_reg !== 1'b1)
      begin
        if (lat == 40)
          give_up;
        tick(1);
        lat++;
      end
      check(lat >= FSTEP * input_filter_time_param + 1 && lat <= FSTEP * input_filter_time_param + 4, 1);
      check(pos_load_value_reg, home_position_data_param);
      check(homing_done_reg, 1);
      check(motion_cmd_reg.active, 0);
    end
    else
    begin
      while (homing_busy_reg !== 1'b1)
      begin
        if (lat == 40)
          give_up;
        tick(1);
        lat++;
      end
      check(motion_cmd_reg.dir, homing_direction_param);
      check(motion_cmd_reg.speed, homing_speed_param);
      check(motion_cmd_reg.accel, pt1_accel_const);
      check(motion_cmd_reg.decel, pt1_decel_const);
      check(homing_done_reg, 0);
      while (pos_load_reg !== 1'b1)
      begin
        if (lat == 4000)
          give_up;
        tick(1);
        lat++;
        if (motion_cmd_reg.speed === creep_speed_param && pc === '1)
          pc = pos;
      end
      check(pos_load_value_reg, home_position_data_param);
      z0 = pos - sh;
      if (m == METHOD_DOG)
      begin
        check(pc >= ds && pc <= ds + 1, 1);
        check(pos, (((ds + dl) >> 4) + 1) * 16 + sh);
      end
      else
      begin
        check(pc >= ds + 4 && pc <= ds + 7, 1);
        check(z0 % 16 == 0 && z0 >= pc + post_dog_travel_param, 1);
        check(z0 < pc + post_dog_travel_param + 17, 1);
      end
    end
    homing_start <= 1'b0;
    tick(20);
    $display("test method %0d ok %0d finished", m, ok);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {auto_manual_select, bcd_input_mode, homing_start, homing_direction_param} = '0;
    {dog_polarity_param, clr, point_table_select, speed_select_inputs} = '0;
    {homing_method_param, homing_speed_param, creep_speed_param} = '0;
    {home_shift_distance_param, home_position_data_param, post_dog_travel_param} = '0;
    {dog_start, dog_len, input_filter_time_param, pt1_accel_const, pt1_decel_const} = '0;
    errors      = 0;
    checks_done = 0;
    loads       = 0;
    seed        = 7650;
    resetn      = 1'b0;
    tick(4);
    resetn <= 1'b1;
    check({homing_busy_reg, homing_done_reg, pos_load_reg, motion_cmd_reg.active}, 0);
    mode(1'b1, 8'h00, 4'h0, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      input_filter_time_param <= 2'(s);
      run(METHOD_DATA, 1'b1);
    end
    input_filter_time_param <= 2'h0;
    for (int i = 0; i < 8; i++)
    begin
      dog_polarity_param     <= i[0];
      homing_direction_param <= i[1];
      run(i[2] ? METHOD_COUNT : METHOD_DOG, 1'b1);
    end
    run(4'h3, 1'b0);
    mode(1'b0, 8'h00, 4'h0, 1'b0);
    run(METHOD_DATA, 1'b0);
    mode(1'b1, 8'h80, 4'h0, 1'b0);
    run(METHOD_DATA, 1'b0);
    mode(1'b1, 8'hA5, 4'h0, 1'b1);
    run(METHOD_DATA, 1'b1);
    mode(1'b1, 8'h00, 4'h2, 1'b1);
    run(METHOD_DATA, 1'b0);
    test_done;
  end
endmodule
